// ---- pkg/line_monitor_regs.svh ----
// Purpose: register offsets, field positions and reset values of the serial port bank
// Assumes: included by bare name from every design file that decodes the bank
// Notes: definitions only
`ifndef LINE_MONITOR_REGS_SVH
`define LINE_MONITOR_REGS_SVH

`define REG_VIOL_LOW 4'h0
`define REG_VIOL_HIGH 4'h1
`define REG_CRC_COUNT 4'h2
`define REG_FRAME_LOSS 4'h3
`define REG_FBIT_COUNT 4'h4
`define REG_STATUS_ONE 4'h5
`define REG_MASK_ONE 4'h6
`define REG_STATUS_TWO 4'h7
`define REG_MASK_TWO 4'h8
`define REG_CTRL_ONE 4'h9
`define REG_CTRL_TWO 4'hA
`define REG_COUNT 11

`define CMD_DIR_BIT 0
`define CMD_ADDR_LSB 1
`define CMD_ADDR_MSB 4
`define CMD_BURST_BIT 7
`define BIT_LAST 3'h7

`define CTRL1_AUTOCLR_BIT 4
`define CTRL2_B8ZS_BIT 2
`define CTRL2_ESF_BIT 4
`define CTRL2_XZERO_BIT 5

`define RST_BYTE 8'h00

`endif

// ---- pkg/line_monitor_pkg.sv ----
// Purpose: shared types of the serial port register bank
// Assumes: nothing
// Notes: offsets and fields live in line_monitor_regs.svh
package line_monitor_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10,
        ST_DONE = 2'b11
    } port_state_e;
endpackage

// ---- logic/sat_counter.sv ----
// Purpose: presettable saturating up counter with overflow pulse
// Assumes: all controls are on clk_sys
// Notes: hold_zero beats load beats clear; an event in a clear cycle counts
`include "line_monitor_regs.svh"
module sat_counter #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // control
    input wire logic hold_zero,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic clear,
    input wire logic event_in,
    // state
    output logic [WIDTH-1:0] count,
    output logic overflow
);
    logic at_max;
    assign at_max = &count;
    assign overflow = event_in && at_max && !hold_zero && !load && !clear;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
        end else if (hold_zero) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (clear) begin
            // the event of the clear cycle is kept, not dropped
            count <= {{(WIDTH-1){1'b0}}, event_in};
        end else if (event_in && !at_max) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    AST_SAT_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (at_max && event_in && !hold_zero && !load && !clear) |-> overflow ##1 (&count))
        else $error("saturated counter moved or did not flag");
    AST_HOLD_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
        hold_zero |=> (count == '0))
        else $error("held counter not zero");
endmodule

// ---- logic/serial_port_error_counters.sv ----
// Purpose: serial host port, register bank and four error counters of a line monitor
// Assumes: line events are one-cycle pulses on clk_sys; sclk only runs while cs_n is low
// Notes: reads come from a shadow bank frozen while cs_n is low
`include "line_monitor_regs.svh"
module serial_port_error_counters (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    // serial port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // line events
    input wire logic sync_loss_flag,
    input wire logic bipolar_violation_event,
    input wire logic b8zs_codeword_event,
    input wire logic zero8_event,
    input wire logic zero16_event,
    input wire logic crc_error_event,
    input wire logic frame_loss_event,
    input wire logic framing_bit_error_event,
    input wire logic [7:0] alarm_one_set,
    input wire logic [3:0] alarm_two_set,
    // configuration and alarm
    output line_monitor_pkg::byte_t receive_control_one,
    output line_monitor_pkg::byte_t receive_control_two,
    output logic alarm_irq
);
    import line_monitor_pkg::*;

    // ---------------- shift clock side ----------------
    logic sclk_rst;
    port_state_e state;
    logic [2:0] bit_cnt;
    byte_t shift_reg;
    byte_t shifted;
    logic [3:0] addr;
    logic burst;
    byte_t rd_byte;
    byte_t wr_data;
    logic [3:0] wr_addr;
    logic wr_tgl;
    logic [3:0] rd_addr;
    logic rd_burst;
    logic rd_tgl;
    byte_t shadow [0:`REG_COUNT-1];

    assign sclk_rst = sys_rst | cs_n;
    assign shifted = {sdi, shift_reg[7:1]};

    always_ff @(posedge sclk or posedge sclk_rst) begin
        if (sclk_rst) begin
            shift_reg <= `RST_BYTE;
            bit_cnt <= 3'h0;
        end else begin
            shift_reg <= shifted;
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    always_ff @(posedge sclk or posedge sclk_rst) begin
        if (sclk_rst) begin
            state <= ST_CMD;
            addr <= 4'h0;
            burst <= 1'b0;
        end else if (bit_cnt == `BIT_LAST) begin
            case (state)
                ST_CMD: begin
                    addr <= shifted[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
                    burst <= shifted[`CMD_BURST_BIT]
                        && (shifted[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `REG_VIOL_LOW);
                    state <= shifted[`CMD_DIR_BIT] ? ST_READ : ST_WRITE;
                end
                ST_WRITE, ST_READ: begin
                    if (burst && addr != `REG_CTRL_TWO) begin
                        addr <= addr + 4'h1;
                    end else begin
                        state <= ST_DONE;
                    end
                end
                default: state <= ST_DONE;
            endcase
        end
    end

    // held past the end of the frame so clk_sys can pick it up at leisure
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_data <= `RST_BYTE;
            wr_addr <= 4'h0;
            wr_tgl <= 1'b0;
        end else if (!cs_n && state == ST_WRITE && bit_cnt == `BIT_LAST) begin
            wr_data <= shifted;
            wr_addr <= addr;
            wr_tgl <= ~wr_tgl;
        end
    end

    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_addr <= 4'h0;
            rd_burst <= 1'b0;
            rd_tgl <= 1'b0;
        end else if (!cs_n && state == ST_READ && bit_cnt == `BIT_LAST) begin
            rd_addr <= addr;
            rd_burst <= burst;
            rd_tgl <= ~rd_tgl;
        end
    end

    // shadow is static while cs_n is low, so this crossing is quasi-static
    always_comb begin
        rd_byte = `RST_BYTE;
        if (addr <= `REG_CTRL_TWO) begin
            rd_byte = shadow[addr];
        end
    end

    always_ff @(negedge sclk or posedge sclk_rst) begin
        if (sclk_rst) begin
            sdo_out <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= (state == ST_READ);
            sdo_out <= (state == ST_READ) ? rd_byte[bit_cnt] : 1'b0;
        end
    end

    // ---------------- system clock side ----------------
    logic busy_meta;
    logic port_busy;
    logic wr_meta;
    logic wr_sync;
    logic wr_seen;
    logic rd_meta;
    logic rd_sync;
    logic rd_seen;
    logic wr_fire;
    logic rd_fire;
    logic auto_clr;
    logic viol_evt;
    logic [3:0] ovf;
    logic [15:0] viol_count;
    byte_t crc_count;
    byte_t frame_loss_count;
    byte_t fbit_count;
    byte_t viol_low_pending;
    byte_t status_one;
    byte_t status_two;
    byte_t mask_one;
    byte_t mask_two;
    byte_t clr_one;
    byte_t clr_two;
    byte_t live [0:`REG_COUNT-1];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy_meta <= 1'b0;
            port_busy <= 1'b0;
            wr_meta <= 1'b0;
            wr_sync <= 1'b0;
            wr_seen <= 1'b0;
            rd_meta <= 1'b0;
            rd_sync <= 1'b0;
            rd_seen <= 1'b0;
        end else begin
            busy_meta <= ~cs_n;
            port_busy <= busy_meta;
            wr_meta <= wr_tgl;
            wr_sync <= wr_meta;
            wr_seen <= wr_sync;
            rd_meta <= rd_tgl;
            rd_sync <= rd_meta;
            rd_seen <= rd_sync;
        end
    end

    assign wr_fire = wr_sync ^ wr_seen;
    assign rd_fire = rd_sync ^ rd_seen;
    assign auto_clr = rd_fire && receive_control_one[`CTRL1_AUTOCLR_BIT];

    always_comb begin
        if (receive_control_two[`CTRL2_XZERO_BIT]) begin
            viol_evt = receive_control_two[`CTRL2_B8ZS_BIT] ? zero8_event : zero16_event;
        end else begin
            viol_evt = bipolar_violation_event
                && !(receive_control_two[`CTRL2_B8ZS_BIT] && b8zs_codeword_event);
        end
    end

    sat_counter #(.WIDTH(16)) viol_ctr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .hold_zero(1'b0),
        .load(wr_fire && wr_addr == `REG_VIOL_HIGH),
        .load_value({wr_data, viol_low_pending}),
        .clear(auto_clr),
        .event_in(viol_evt),
        .count(viol_count),
        .overflow(ovf[0])
    );

    sat_counter #(.WIDTH(8)) crc_ctr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .hold_zero(!receive_control_two[`CTRL2_ESF_BIT]),
        .load(wr_fire && wr_addr == `REG_CRC_COUNT),
        .load_value(wr_data),
        .clear(auto_clr),
        .event_in(crc_error_event && !sync_loss_flag),
        .count(crc_count),
        .overflow(ovf[1])
    );

    sat_counter #(.WIDTH(8)) frame_loss_ctr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .hold_zero(1'b0),
        .load(wr_fire && wr_addr == `REG_FRAME_LOSS),
        .load_value(wr_data),
        .clear(auto_clr),
        .event_in(frame_loss_event && !sync_loss_flag),
        .count(frame_loss_count),
        .overflow(ovf[2])
    );

    sat_counter #(.WIDTH(8)) fbit_ctr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .hold_zero(1'b0),
        .load(wr_fire && wr_addr == `REG_FBIT_COUNT),
        .load_value(wr_data),
        .clear(auto_clr),
        .event_in(framing_bit_error_event && !sync_loss_flag),
        .count(fbit_count),
        .overflow(ovf[3])
    );

    // writable configuration; status and unmapped writes are dropped
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            viol_low_pending <= `RST_BYTE;
            mask_one <= `RST_BYTE;
            mask_two <= `RST_BYTE;
            receive_control_one <= `RST_BYTE;
            receive_control_two <= `RST_BYTE;
        end else if (wr_fire) begin
            case (wr_addr)
                `REG_VIOL_LOW: viol_low_pending <= wr_data;
                `REG_MASK_ONE: mask_one <= wr_data;
                `REG_MASK_TWO: mask_two <= wr_data;
                `REG_CTRL_ONE: receive_control_one <= wr_data;
                `REG_CTRL_TWO: receive_control_two <= wr_data;
                default: viol_low_pending <= viol_low_pending;
            endcase
        end
    end

    // only single reads clear status; only bits the host saw are cleared
    always_comb begin
        clr_one = `RST_BYTE;
        clr_two = `RST_BYTE;
        if (rd_fire && !rd_burst && rd_addr == `REG_STATUS_ONE) begin
            clr_one = shadow[`REG_STATUS_ONE];
        end
        if (rd_fire && !rd_burst && rd_addr == `REG_STATUS_TWO) begin
            clr_two = shadow[`REG_STATUS_TWO];
        end
    end

    // alarm and saturation flags; a set beats a clear in the same cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            status_one <= `RST_BYTE;
            status_two <= `RST_BYTE;
        end else begin
            status_one <= (status_one & ~clr_one) | alarm_one_set;
            status_two <= (status_two & ~clr_two) | {alarm_two_set, ovf};
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_irq <= 1'b0;
        end else begin
            alarm_irq <= (|(status_one & mask_one)) | (|(status_two & mask_two));
        end
    end

    always_comb begin
        live[`REG_VIOL_LOW] = viol_count[7:0];
        live[`REG_VIOL_HIGH] = viol_count[15:8];
        live[`REG_CRC_COUNT] = crc_count;
        live[`REG_FRAME_LOSS] = frame_loss_count;
        live[`REG_FBIT_COUNT] = fbit_count;
        live[`REG_STATUS_ONE] = status_one;
        live[`REG_MASK_ONE] = mask_one;
        live[`REG_STATUS_TWO] = status_two;
        live[`REG_MASK_TWO] = mask_two;
        live[`REG_CTRL_ONE] = receive_control_one;
        live[`REG_CTRL_TWO] = receive_control_two;
    end

    // dual buffer: live counters keep running, shadow frozen while busy
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                shadow[i] <= `RST_BYTE;
            end
        end else if (!port_busy) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                shadow[i] <= live[i];
            end
        end
    end

    // ---------------- checks ----------------
    AST_HIZ_WRITE: assert property (@(negedge sclk) disable iff (sclk_rst)
        (state == ST_WRITE) |=> !sdo_oe)
        else $error("serial output driven during write");
    AST_SDO_BIT: assert property (@(posedge sclk) disable iff (sclk_rst)
        (state == ST_READ && sdo_oe) |-> (sdo_out == rd_byte[bit_cnt]))
        else $error("serial output bit does not match register");
    AST_DIR_DECODE: assert property (@(posedge sclk) disable iff (sclk_rst)
        (state == ST_CMD && bit_cnt == `BIT_LAST)
        |=> ((state == ST_READ) == $past(shifted[`CMD_DIR_BIT])))
        else $error("direction bit misdecoded");
    AST_BURST_DECODE: assert property (@(posedge sclk) disable iff (sclk_rst)
        (state == ST_CMD && bit_cnt == `BIT_LAST)
        |=> (burst == ($past(shifted[`CMD_BURST_BIT])
            && $past(shifted[`CMD_ADDR_MSB:`CMD_ADDR_LSB]) == `REG_VIOL_LOW)))
        else $error("burst decode wrong");
    // checked on the falling edge: a single write has no rising edge after its last bit
    AST_WRITE_CAPTURE: assert property (@(negedge sclk) disable iff (sclk_rst)
        ($past(state) == ST_WRITE && bit_cnt == 3'h0)
        |-> (wr_data == shift_reg) && (wr_tgl != $past(wr_tgl)))
        else $error("written byte not captured");
    AST_WRITE_APPLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_fire && wr_addr == `REG_CTRL_ONE) |=> (receive_control_one == $past(wr_data)))
        else $error("control write not applied");
    AST_BURST_KEEPS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rd_fire && rd_burst && alarm_one_set == `RST_BYTE)
        |=> (status_one == $past(status_one)))
        else $error("burst read changed status");
    AST_STATUS_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ovf[1] |=> status_two[1])
        else $error("saturation event lost");
    AST_SYNC_STOP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (sync_loss_flag && !wr_fire && !rd_fire) |=> $stable(frame_loss_count))
        else $error("frame loss counter moved during sync loss");
    AST_AUTO_CLEAR: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rd_fire && receive_control_one[`CTRL1_AUTOCLR_BIT] && !wr_fire)
        |=> (fbit_count <= 8'h01 && viol_count <= 16'h0001))
        else $error("auto clear did not zero counters");
    AST_CODEWORD_SKIP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!receive_control_two[`CTRL2_XZERO_BIT] && receive_control_two[`CTRL2_B8ZS_BIT]
            && b8zs_codeword_event && !wr_fire && !rd_fire)
        |=> $stable(viol_count))
        else $error("code word counted as violation");
    AST_SHADOW_FROZEN: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (port_busy && $past(port_busy)) |-> $stable(shadow[`REG_CRC_COUNT]))
        else $error("shadow changed while port busy");

    COV_BURST_END: cover property (@(posedge sclk) disable iff (sclk_rst)
        state == ST_READ && burst && addr == `REG_CTRL_TWO);
    COV_SINGLE_WRITE: cover property (@(posedge clk_sys) disable iff (sys_rst)
        wr_fire && wr_addr == `REG_MASK_TWO);
    COV_SATURATE: cover property (@(posedge clk_sys) disable iff (sys_rst) ovf[0]);
endmodule

// ---- verif/serial_host.sv ----
// Purpose: host model that drives the serial port of the error counter bank
// Assumes: shift clock of 48 ns, idle low, running only inside a frame
// Notes: sdo is sampled on the rising edge; a floating sdo reads as unknown
module serial_host (
    // serial port
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    int oe_hits;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        oe_hits = 0;
    end

    always @(posedge sclk) begin
        if (sdo_oe) begin
            oe_hits++;
        end
    end

    // cut stops the frame early so that an abort can be commanded
    task automatic xfer(input logic [7:0] cmd, input int n, input int cut,
                        input logic [87:0] wd, output logic [87:0] rd);
        logic [95:0] bits;
        bits = {wd, cmd};
        rd = '0;
        oe_hits = 0;
        // gap lets the bank refresh its read copy between frames
        #200;
        cs_n = 1'b0;
        for (int i = 0; i < 8 + 8 * n && i < cut; i++) begin
            sdi = bits[i];
            #24;
            sclk = 1'b1;
            if (i >= 8) begin
                rd[i - 8] = sdo_oe ? sdo_out : 1'bx;
            end
            #24;
            sclk = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        sdi = ~sdi;
        #200;
    endtask
endmodule

// ---- verif/serial_port_error_counters_tb_top.sv ----
// Purpose: self-checking bench of the serial port register bank and counters
// Assumes: line events are one clk_sys pulses driven on the falling edge
// Notes: alarm_two_set is tied low; status two is reached through the counters
`include "line_monitor_regs.svh"
`define CHK(a, b) cmp(64'(a), 64'(b))
module serial_port_error_counters_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic sys_rst;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    logic sync_loss_flag;
    logic [6:0] evt;
    logic [7:0] a1;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic alarm_irq;
    logic [87:0] r;
    logic [7:0] d;
    int errors;
    int checked;
    int cycles;

    serial_port_error_counters dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sync_loss_flag(sync_loss_flag),
        .bipolar_violation_event(evt[0]), .b8zs_codeword_event(evt[1]),
        .zero8_event(evt[2]), .zero16_event(evt[3]), .crc_error_event(evt[4]),
        .frame_loss_event(evt[5]), .framing_bit_error_event(evt[6]),
        .alarm_one_set(a1), .alarm_two_set(4'h0), .receive_control_one(ctl1),
        .receive_control_two(ctl2), .alarm_irq(alarm_irq)
    );

    serial_host host (
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic [87:0] x;
        host.xfer({3'b000, a, 1'b0}, 1, 99, {80'h0, v}, x);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        logic [87:0] x;
        host.xfer({3'b000, a, 1'b1}, 1, 99, 88'h0, x);
        v = x[7:0];
    endtask

    task automatic pulse(input logic [6:0] m, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            evt = m;
            @(negedge clk_sys);
            evt = '0;
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // limit is several times the expected run of about 1200 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            $display("[FAIL] t=%0t got %0h exp %0h", $time, cycles, 0);
            print_verdict();
        end
    end

    initial begin
        sys_rst = 1'b1;
        sync_loss_flag = 1'b0;
        evt = '0;
        a1 = '0;
        errors = 0;
        checked = 0;
        cycles = 0;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        host.xfer(8'h81, 11, 999, 88'h0, r);
        for (int i = 0; i < 11; i++) `CHK(r[8 * i +: 8], 8'h00);
        done("reset burst");
        wr(`REG_MASK_ONE, 8'hA5);
        `CHK(host.oe_hits, 0);
        wr(`REG_MASK_TWO, 8'h0F);
        wr(`REG_CTRL_TWO, 8'h10);
        wr(`REG_STATUS_ONE, 8'hFF);
        rd(`REG_MASK_ONE, d);
        `CHK(d, 8'hA5);
        rd(`REG_MASK_TWO, d);
        `CHK(d, 8'h0F);
        `CHK(ctl2, 8'h10);
        rd(`REG_STATUS_ONE, d);
        `CHK(d, 8'h00);
        host.xfer({3'b000, `REG_MASK_ONE, 1'b0}, 1, 12, 88'h0, r);
        `CHK(sdo_oe, 1'b0);
        rd(`REG_MASK_ONE, d);
        `CHK(d, 8'hA5);
        done("register access");
        wr(`REG_FRAME_LOSS, 8'hFE);
        pulse(7'h20, 3);
        @(negedge clk_sys);
        a1 = 8'h01;
        @(negedge clk_sys);
        a1 = 8'h00;
        repeat (3) @(negedge clk_sys);
        `CHK(alarm_irq, 1'b1);
        host.xfer(8'h81, 11, 999, 88'h0, r);
        `CHK(r[8 * 3 +: 8], 8'hFF);
        `CHK(r[8 * 5 +: 8], 8'h01);
        `CHK(r[8 * 7 +: 8], 8'h04);
        `CHK(r[8 * 8 +: 8], 8'h0F);
        rd(`REG_STATUS_TWO, d);
        `CHK(d, 8'h04);
        rd(`REG_STATUS_TWO, d);
        `CHK(d, 8'h00);
        rd(`REG_STATUS_ONE, d);
        `CHK(d, 8'h01);
        rd(`REG_STATUS_ONE, d);
        `CHK(alarm_irq, 1'b0);
        done("saturation and status");
        @(negedge clk_sys);
        sync_loss_flag = 1'b1;
        pulse(7'h71, 2);
        sync_loss_flag = 1'b0;
        pulse(7'h10, 1);
        rd(`REG_VIOL_LOW, d);
        `CHK(d, 8'h02);
        rd(`REG_CRC_COUNT, d);
        `CHK(d, 8'h01);
        rd(`REG_FBIT_COUNT, d);
        `CHK(d, 8'h00);
        wr(`REG_CTRL_TWO, 8'h00);
        pulse(7'h10, 1);
        rd(`REG_CRC_COUNT, d);
        `CHK(d, 8'h00);
        done("sync loss and mode");
        wr(`REG_VIOL_LOW, 8'hFE);
        wr(`REG_VIOL_HIGH, 8'hFF);
        pulse(7'h01, 3);
        host.xfer(8'h81, 8, 999, 88'h0, r);
        `CHK(r[15:0], 16'hFFFF);
        `CHK(r[8 * 7 +: 8], 8'h01);
        wr(`REG_VIOL_LOW, 8'h00);
        wr(`REG_VIOL_HIGH, 8'h00);
        wr(`REG_CTRL_TWO, 8'h04);
        pulse(7'h03, 2);
        pulse(7'h01, 1);
        wr(`REG_CTRL_TWO, 8'h24);
        pulse(7'h0D, 1);
        pulse(7'h08, 1);
        wr(`REG_CTRL_TWO, 8'h20);
        pulse(7'h04, 1);
        pulse(7'h09, 1);
        rd(`REG_VIOL_LOW, d);
        `CHK(d, 8'h03);
        done("violation counter");
        wr(`REG_CTRL_ONE, 8'h10);
        `CHK(ctl1, 8'h10);
        rd(`REG_MASK_TWO, d);
        host.xfer(8'h81, 5, 999, 88'h0, r);
        `CHK(r[39:0], 40'h0);
        wr(`REG_CTRL_ONE, 8'h00);
        pulse(7'h20, 2);
        rd(`REG_FRAME_LOSS, d);
        `CHK(d, 8'h02);
        // events land while the frame is open: the read shows the frozen copy
        fork
            rd(`REG_FRAME_LOSS, d);
            begin
                #600;
                pulse(7'h20, 2);
            end
        join
        `CHK(d, 8'h02);
        rd(`REG_FRAME_LOSS, d);
        `CHK(d, 8'h04);
        done("auto clear");
        print_verdict();
    end
endmodule
